// ---- include/fault_rs_pkg.sv ----
package fault_rs_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] REG_CFG_IDX = 12'h405;
    localparam logic [11:0] REG_IRQ_STAT_IDX = 12'h406;
    localparam logic [11:0] REG_IRQ_MASK_IDX = 12'h407;
    localparam logic [11:0] REG_STATUS_IDX = 12'h408;

    // configuration field
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_UNIDIR_BIT = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam logic [1:0] MODE_BIDIR = 2'h1;
    localparam logic [1:0] MODE_UNIDIR = 2'h3;

    // interrupt status bits
    localparam int IRQ_LOCAL_BIT = 0;
    localparam int IRQ_REMOTE_BIT = 1;
    localparam int IRQ_CLEAR_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;

    // column coding
    localparam logic [7:0] SEQ_CTRL = 8'h01;
    localparam logic [7:0] SEQ_CODE = 8'h9c;
    localparam logic [7:0] FAULT_LOCAL = 8'h01;
    localparam logic [7:0] FAULT_REMOTE = 8'h02;
    localparam logic [7:0] IDLE_CTRL = 8'hff;
    localparam logic [63:0] IDLE_DATA = 64'h0707070707070707;
    localparam int SEQ_CODE_LSB = 0;
    localparam int SEQ_FAULT_LSB = 24;

    // fault detection defaults
    localparam int SEQ_NEEDED = 4;
    localparam int COL_LIMIT = 128;

    typedef enum logic [1:0] {
        LF_OK = 2'h0,
        LF_LOCAL = 2'h1,
        LF_REMOTE = 2'h3
    } link_fault_t;

    // sequence ordered set column carrying a fault code
    function automatic logic [63:0] seqColumn(input logic [7:0] code);
        logic [63:0] col;
        col = 64'h0;
        col[SEQ_CODE_LSB +: 8] = SEQ_CODE;
        col[SEQ_FAULT_LSB +: 8] = code;
        return col;
    endfunction

endpackage

// ---- verilog/fault_sequence_monitor.sv ----
`timescale 1ns/1ps
module fault_sequence_monitor #(
    parameter int SEQ_NEEDED = fault_rs_pkg::SEQ_NEEDED,
    parameter int COL_LIMIT = fault_rs_pkg::COL_LIMIT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // received column
    input wire logic [63:0] rxData,
    input wire logic [7:0] rxCtrl,
    // fault state
    output fault_rs_pkg::link_fault_t linkFault
);

    localparam int CW = $clog2(COL_LIMIT + 1);
    localparam int SW = $clog2(SEQ_NEEDED + 1);

    initial begin
        if (SEQ_NEEDED < 1 || COL_LIMIT < 2) begin
            $error("fault_sequence_monitor: bad parameters");
        end
    end

    logic [CW-1:0] colCnt;
    logic [SW-1:0] seqCnt;
    fault_rs_pkg::link_fault_t lastType;
    logic isSeq;
    fault_rs_pkg::link_fault_t seqType;
    logic gapOk;

    always_comb begin
        isSeq = 1'b0;
        seqType = fault_rs_pkg::LF_OK;
        if (rxCtrl == fault_rs_pkg::SEQ_CTRL &&
            rxData[fault_rs_pkg::SEQ_CODE_LSB +: 8] == fault_rs_pkg::SEQ_CODE) begin
            if (rxData[fault_rs_pkg::SEQ_FAULT_LSB +: 8] == fault_rs_pkg::FAULT_LOCAL) begin
                isSeq = 1'b1;
                seqType = fault_rs_pkg::LF_LOCAL;
            end else if (rxData[fault_rs_pkg::SEQ_FAULT_LSB +: 8] == fault_rs_pkg::FAULT_REMOTE) begin
                isSeq = 1'b1;
                seqType = fault_rs_pkg::LF_REMOTE;
            end
        end
    end

    // previous sequence less than COL_LIMIT columns ago
    assign gapOk = colCnt < CW'(COL_LIMIT);

    // columns since the last fault sequence, saturating at the limit
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            colCnt <= CW'(COL_LIMIT);
        end else if (clkEn) begin
            if (isSeq) begin
                colCnt <= '0;
            end else if (gapOk) begin
                colCnt <= colCnt + CW'(1);
            end
        end
    end

    // run of same-valued sequences
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            seqCnt <= '0;
            lastType <= fault_rs_pkg::LF_OK;
        end else if (clkEn) begin
            if (isSeq) begin
                lastType <= seqType;
                if (seqType == lastType && gapOk && seqCnt != '0) begin // [RULE8]
                    if (seqCnt != SW'(SEQ_NEEDED)) begin
                        seqCnt <= seqCnt + SW'(1);
                    end
                end else begin
                    seqCnt <= SW'(1);
                end
            end else if (colCnt == CW'(COL_LIMIT - 1)) begin
                seqCnt <= '0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            linkFault <= fault_rs_pkg::LF_OK; // [RULE15]
        end else if (clkEn) begin
            if (isSeq && seqType == lastType && gapOk && seqCnt == SW'(SEQ_NEEDED - 1)) begin
                linkFault <= seqType; // [RULE8]
            end else if (isSeq && SEQ_NEEDED == 1) begin
                linkFault <= seqType; // [RULE8]
            end else if (!isSeq && colCnt == CW'(COL_LIMIT - 1)) begin
                linkFault <= fault_rs_pkg::LF_OK; // [RULE9]
            end
        end
    end

endmodule

// ---- verilog/link_fault_reconciliation.sv ----
// Behaviour
// (RULE1) Fault signalling toward the link is off after reset and turns on only when software sets config bit 0.
// (RULE2) A config field of 01 selects normal bidirectional fault signalling.
// (RULE3) In bidirectional mode a local fault makes the transmit path send remote fault sequences.
// (RULE4) In bidirectional mode a remote fault makes the transmit path send idle columns instead of client data.
// (RULE5) A config field of 11 selects one-way operation, with fault sequences placed in the interpacket gaps.
// (RULE6) Receiving remote or local fault sequences sets the matching fault status output.
// (RULE7) The status output clears after valid data for more than 127 columns.
// (RULE8) The fault state takes a value after four same-valued sequences, each under 128 columns apart, none differing.
// (RULE9) The fault state returns to OK after any 128 columns with no fault sequence.
// (RULE10) The fault status outputs follow detection regardless of the config register.
// (RULE11) Both fault status outputs are clocked by the receive clock.
// (RULE12) The one-way mode output mirrors config bit 1 of the register at index 0x405.
// (RULE13) The report enable output mirrors config bit 0 of the register at index 0x405.
// (RULE14) The one-way mode and report enable outputs are clocked by the transmit clock.
// (RULE15) Fault status outputs and the fault state are zero or OK while reset is held.
`timescale 1ns/1ps
module link_fault_reconciliation #(
    parameter int SEQ_NEEDED = fault_rs_pkg::SEQ_NEEDED,
    parameter int COL_LIMIT = fault_rs_pkg::COL_LIMIT
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    // apb slave
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive columns from the pcs
    input wire logic [63:0] rxData,
    input wire logic [7:0] rxCtrl,
    // transmit columns from the mac
    input wire logic [63:0] macTxData,
    input wire logic [7:0] macTxCtrl,
    // transmit columns to the pcs
    output logic [63:0] pcsTxData,
    output logic [7:0] pcsTxCtrl,
    // fault status and configuration mirrors
    output logic remoteFaultStatus,
    output logic localFaultStatus,
    output logic unidirectionalEn,
    output logic faultReportEn,
    // interrupt
    output logic irq
);

    initial begin
        if (SEQ_NEEDED < 1 || COL_LIMIT < 2) begin
            $error("link_fault_reconciliation: bad parameters");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // receive fault detection

    fault_rs_pkg::link_fault_t linkFault;
    logic localNow;
    logic remoteNow;

    fault_sequence_monitor #(
        .SEQ_NEEDED(SEQ_NEEDED),
        .COL_LIMIT(COL_LIMIT)
    ) monitor (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .rxData(rxData),
        .rxCtrl(rxCtrl),
        .linkFault(linkFault)
    );

    assign localNow = linkFault == fault_rs_pkg::LF_LOCAL;
    assign remoteNow = linkFault == fault_rs_pkg::LF_REMOTE;

    // status follows the fault state only, never the config field
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            localFaultStatus <= 1'b0; // [RULE15]
            remoteFaultStatus <= 1'b0; // [RULE15]
        end else if (clkEn) begin
            localFaultStatus <= localNow; // [RULE6] [RULE7] [RULE10] [RULE11]
            remoteFaultStatus <= remoteNow; // [RULE6] [RULE7] [RULE10] [RULE11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [1:0] faultCfg;
    logic [fault_rs_pkg::IRQ_WIDTH-1:0] irqStatus;
    logic [fault_rs_pkg::IRQ_WIDTH-1:0] irqMask;
    logic [fault_rs_pkg::IRQ_WIDTH-1:0] irqEvents;
    logic [29:0] regIdx;
    logic aligned;
    logic hitCfg;
    logic hitStat;
    logic hitMask;
    logic hitStatus;
    logic mapped;
    logic setupPhase;
    logic accessWrite;
    logic [31:0] next_prdata;
    logic prevLocal;
    logic prevRemote;
    logic prevAny;

    assign regIdx = paddr[31:2];
    assign aligned = paddr[1:0] == 2'h0;
    assign hitCfg = aligned && regIdx == 30'(fault_rs_pkg::REG_CFG_IDX);
    assign hitStat = aligned && regIdx == 30'(fault_rs_pkg::REG_IRQ_STAT_IDX);
    assign hitMask = aligned && regIdx == 30'(fault_rs_pkg::REG_IRQ_MASK_IDX);
    assign hitStatus = aligned && regIdx == 30'(fault_rs_pkg::REG_STATUS_IDX);
    assign mapped = hitCfg || hitStat || hitMask || hitStatus;
    assign setupPhase = psel && !penable;
    assign accessWrite = clkEn && psel && penable && pwrite && mapped && pstrb[0];

    // zero wait states while the block runs; a frozen block holds the bus
    assign pready = clkEn;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        next_prdata = 32'h0;
        if (hitCfg) begin
            next_prdata[1:0] = faultCfg;
        end else if (hitStat) begin
            next_prdata[fault_rs_pkg::IRQ_WIDTH-1:0] = irqStatus;
        end else if (hitMask) begin
            next_prdata[fault_rs_pkg::IRQ_WIDTH-1:0] = irqMask;
        end else if (hitStatus) begin
            next_prdata[1:0] = {remoteFaultStatus, localFaultStatus};
        end
    end

    // read data captured in the setup cycle, stable through the access phase
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (clkEn && setupPhase) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            faultCfg <= fault_rs_pkg::CFG_RESET; // [RULE1]
        end else if (accessWrite && hitCfg) begin
            faultCfg <= pwdata[1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irqMask <= fault_rs_pkg::IRQ_RESET;
        end else if (accessWrite && hitMask) begin
            irqMask <= pwdata[fault_rs_pkg::IRQ_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // interrupt events

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prevLocal <= 1'b0;
            prevRemote <= 1'b0;
            prevAny <= 1'b0;
        end else if (clkEn) begin
            prevLocal <= localNow;
            prevRemote <= remoteNow;
            prevAny <= localNow || remoteNow;
        end
    end

    always_comb begin
        irqEvents = '0;
        irqEvents[fault_rs_pkg::IRQ_LOCAL_BIT] = localNow && !prevLocal;
        irqEvents[fault_rs_pkg::IRQ_REMOTE_BIT] = remoteNow && !prevRemote;
        irqEvents[fault_rs_pkg::IRQ_CLEAR_BIT] = prevAny && !(localNow || remoteNow);
    end

    // a new event in the clearing cycle survives the write-one clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irqStatus <= fault_rs_pkg::IRQ_RESET;
        end else if (clkEn) begin
            if (accessWrite && hitStat) begin
                irqStatus <= (irqStatus & ~pwdata[fault_rs_pkg::IRQ_WIDTH-1:0]) | irqEvents;
            end else begin
                irqStatus <= irqStatus | irqEvents;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else if (clkEn) begin
            irq <= |(irqStatus & irqMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // configuration mirrors

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            unidirectionalEn <= 1'b0;
            faultReportEn <= 1'b0;
        end else if (clkEn) begin
            unidirectionalEn <= faultCfg[fault_rs_pkg::CFG_UNIDIR_BIT]; // [RULE12] [RULE14]
            faultReportEn <= faultCfg[fault_rs_pkg::CFG_EN_BIT]; // [RULE13] [RULE14]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // transmit path

    logic macIdle;
    logic [63:0] next_pcsTxData;
    logic [7:0] next_pcsTxCtrl;

    assign macIdle = macTxCtrl == fault_rs_pkg::IDLE_CTRL && macTxData == fault_rs_pkg::IDLE_DATA;

    always_comb begin
        next_pcsTxData = macTxData;
        next_pcsTxCtrl = macTxCtrl;
        if (faultCfg == fault_rs_pkg::MODE_BIDIR) begin // [RULE1] [RULE2]
            if (localNow) begin
                next_pcsTxData = fault_rs_pkg::seqColumn(fault_rs_pkg::FAULT_REMOTE); // [RULE3]
                next_pcsTxCtrl = fault_rs_pkg::SEQ_CTRL;
            end else if (remoteNow) begin
                next_pcsTxData = fault_rs_pkg::IDLE_DATA; // [RULE4]
                next_pcsTxCtrl = fault_rs_pkg::IDLE_CTRL;
            end
        end else if (faultCfg == fault_rs_pkg::MODE_UNIDIR) begin
            // one-way: client data keeps flowing, gaps carry the remote fault sequence
            if (localNow && macIdle) begin
                next_pcsTxData = fault_rs_pkg::seqColumn(fault_rs_pkg::FAULT_REMOTE); // [RULE5]
                next_pcsTxCtrl = fault_rs_pkg::SEQ_CTRL;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pcsTxData <= fault_rs_pkg::IDLE_DATA;
            pcsTxCtrl <= fault_rs_pkg::IDLE_CTRL;
        end else if (clkEn) begin
            pcsTxData <= next_pcsTxData;
            pcsTxCtrl <= next_pcsTxCtrl;
        end
    end

endmodule

// ---- test/link_fault_reconciliation_assertions.sv ----
`timescale 1ns/1ps
module link_fault_reconciliation_checker #(
    parameter int COL_LIMIT = fault_rs_pkg::COL_LIMIT
) (
    // clock and apb
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // columns
    input wire logic [63:0] rxData,
    input wire logic [7:0] rxCtrl,
    input wire logic [63:0] macTxData,
    input wire logic [7:0] macTxCtrl,
    input wire logic [63:0] pcsTxData,
    input wire logic [7:0] pcsTxCtrl,
    // status
    input wire logic remoteFaultStatus,
    input wire logic localFaultStatus,
    input wire logic unidirectionalEn,
    input wire logic faultReportEn
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    logic cfgWr;
    logic isSeq;
    logic [15:0] cleanCnt;
    assign cfgWr = psel && penable && pwrite && clkEn && pstrb[0] && paddr == 32'h1014;
    assign isSeq = rxCtrl == 8'h01 && rxData[7:0] == 8'h9c;
    // columns seen since the last sequence column
    always_ff @(posedge core_clk) begin
        if (!rst_b || isSeq) begin
            cleanCnt <= 16'h0;
        end else if (clkEn && cleanCnt != 16'hffff) begin
            cleanCnt <= cleanCnt + 16'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    chk_cfg_mirror: assert property (
        cfgWr |-> ##2 {unidirectionalEn, faultReportEn} == $past(pwdata[1:0], 2))
        else $error("mirror outputs differ from written config");
    chk_reset_clear: assert property (disable iff (1'b0)
        !rst_b && clkEn |=> !localFaultStatus && !remoteFaultStatus && !faultReportEn && !unidirectionalEn)
        else $error("outputs not cleared by reset");
    chk_local_rise: assert property (
        $rose(localFaultStatus) |-> $past(isSeq && rxData[31:24] == 8'h01, 2))
        else $error("local status rose without a local sequence");
    chk_remote_rise: assert property (
        $rose(remoteFaultStatus) |-> $past(isSeq && rxData[31:24] == 8'h02, 2))
        else $error("remote status rose without a remote sequence");
    chk_fault_clear: assert property (
        $fell(localFaultStatus || remoteFaultStatus) |-> cleanCnt inside {[COL_LIMIT - 1:COL_LIMIT + 2]})
        else $error("fault status cleared at the wrong column");
    chk_clear_bound: assert property (
        cleanCnt == COL_LIMIT + 3 |-> !localFaultStatus && !remoteFaultStatus)
        else $error("fault status held past the clean span");
    chk_local_tx: assert property (
        localFaultStatus && faultReportEn && $stable({unidirectionalEn, faultReportEn})
        && (!unidirectionalEn || $past(macTxCtrl) == 8'hff) |-> pcsTxCtrl == 8'h01 && pcsTxData == 64'h200009c)
        else $error("no remote fault sequence sent");
    chk_remote_tx: assert property (
        remoteFaultStatus && faultReportEn && !unidirectionalEn && $stable({unidirectionalEn, faultReportEn})
        |-> pcsTxCtrl == 8'hff && pcsTxData == 64'h0707070707070707)
        else $error("no idle sent during remote fault");
    chk_pass_tx: assert property (
        !faultReportEn && $stable(faultReportEn) && $past(rst_b)
        |-> {pcsTxCtrl, pcsTxData} == $past({macTxCtrl, macTxData}))
        else $error("column altered while signalling is off");
    cov_local: cover property ($rose(localFaultStatus));
    cov_remote: cover property ($rose(remoteFaultStatus));
    cov_clear: cover property ($fell(localFaultStatus));
endmodule

// ---- test/pcs_column_source.sv ----
`timescale 1ns/1ps
module pcs_column_source (
    // clock and column select: 0 data, 1 local, 2 remote, 3 idle
    input wire logic core_clk,
    input wire logic [1:0] kind,
    // received column
    output logic [63:0] rxData,
    output logic [7:0] rxCtrl
);
    logic [63:0] pat = 64'h0;
    // data bytes change every column
    always_ff @(posedge core_clk) begin
        pat <= pat + 64'h0101010101010101;
    end
    always_comb begin
        case (kind)
            2'h0: {rxCtrl, rxData} = {8'h00, pat};
            2'h1: {rxCtrl, rxData} = {8'h01, 64'h000000000100009c};
            2'h2: {rxCtrl, rxData} = {8'h01, 64'h000000000200009c};
            default: {rxCtrl, rxData} = {8'hff, 64'h0707070707070707};
        endcase
    end
endmodule

// ---- test/tb_link_fault_reconciliation.sv ----
`timescale 1ns/1ps
`define CK(nm, ex, got) begin \
    nCompared++; \
    if ((got) !== (ex)) begin \
        fails++; \
        $display("unexpected %s: expected %h, seen %h", nm, ex, got); \
    end \
end
module tb_link_fault_reconciliation;
    localparam int CL = 8;
    localparam logic [63:0] RSEQ = 64'h200009c;
    localparam logic [63:0] MD = 64'h0123456789abcdef;
    localparam logic [63:0] ID = 64'h0707070707070707;
    typedef struct {logic [31:0] a, w; logic [3:0] s; logic [31:0] r; logic err;} row_t;
    logic core_clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, pready, pslverr, irq;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, q, prdata;
    logic [3:0] pstrb = 4'hf;
    logic [1:0] kind = 2'h3;
    logic [63:0] macTxData = ID, rxData, pcsTxData;
    logic [7:0] macTxCtrl = 8'hff, rxCtrl, pcsTxCtrl;
    logic remoteFaultStatus, localFaultStatus, unidirectionalEn, faultReportEn;
    int fails = 0;
    int nCompared = 0;
    row_t rows [8] = '{'{32'h1014, 32'h1, 4'hf, 32'h1, 1'b0}, '{32'h1014, 32'h3, 4'hf, 32'h3, 1'b0},
        '{32'h1014, 32'h2, 4'h0, 32'h3, 1'b0}, '{32'h1014, 32'h2, 4'hf, 32'h2, 1'b0},
        '{32'h101c, 32'h7, 4'hf, 32'h7, 1'b0}, '{32'h1020, 32'h3, 4'hf, 32'h0, 1'b0},
        '{32'h1000, 32'h5, 4'hf, 32'h0, 1'b1}, '{32'h1016, 32'h1, 4'hf, 32'h0, 1'b1}};
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    link_fault_reconciliation #(.COL_LIMIT(CL)) dut_u (.core_clk, .rst_b, .clkEn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rxData, .rxCtrl, .macTxData, .macTxCtrl,
        .pcsTxData, .pcsTxCtrl, .remoteFaultStatus, .localFaultStatus, .unidirectionalEn, .faultReportEn, .irq);
    pcs_column_source far_u (.core_clk, .kind, .rxData, .rxCtrl);
    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic col(input logic [1:0] k, input int n);
        kind <= k;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic seqs(input logic [1:0] k, input int cnt, input int gap);
        repeat (cnt) begin
            col(k, 1);
            col(2'h0, gap);
        end
    endtask
    initial begin
        repeat (3000) @(posedge core_clk);
        fails++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        `CK("faultReportEn", 1'b0, faultReportEn)
        apb(1'b0, 32'h1014, 32'h0, 4'hf);
        `CK("config", 32'h0, q)
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w, rows[i].s);
            `CK("write error", rows[i].err, e)
            apb(1'b0, rows[i].a, 32'h0, 4'hf);
            `CK("read", {rows[i].err, rows[i].r}, {e, q})
            if (rows[i].a == 32'h1014) begin
                `CK("mirrors", rows[i].r[1:0], {unidirectionalEn, faultReportEn})
            end
        end
        $display("test registers done");
        apb(1'b1, 32'h1014, 32'h1, 4'hf);
        macTxData <= MD;
        macTxCtrl <= 8'h00;
        seqs(2'h1, 3, 2);
        `CK("localFaultStatus", 1'b0, localFaultStatus)
        seqs(2'h1, 1, 2);
        `CK("localFaultStatus", 1'b1, localFaultStatus)
        `CK("pcsTxData", RSEQ, pcsTxData)
        `CK("pcsTxCtrl", 8'h01, pcsTxCtrl)
        kind <= 2'h1;
        apb(1'b0, 32'h1020, 32'h0, 4'hf);
        `CK("fault status", 32'h1, q)
        `CK("irq", 1'b1, irq)
        apb(1'b1, 32'h1014, 32'h3, 4'hf);
        macTxData <= ID;
        macTxCtrl <= 8'hff;
        repeat (3) @(posedge core_clk);
        `CK("pcsTxData", RSEQ, pcsTxData)
        macTxData <= MD;
        macTxCtrl <= 8'h00;
        repeat (2) @(posedge core_clk);
        `CK("pcsTxData", MD, pcsTxData)
        apb(1'b1, 32'h1014, 32'h1, 4'hf);
        col(2'h0, CL - 2);
        `CK("localFaultStatus", 1'b1, localFaultStatus)
        col(2'h0, 5);
        `CK("localFaultStatus", 1'b0, localFaultStatus)
        apb(1'b0, 32'h1018, 32'h0, 4'hf);
        `CK("events", 32'h5, q)
        apb(1'b1, 32'h1018, 32'h5, 4'hf);
        @(posedge core_clk);
        `CK("irq", 1'b0, irq)
        $display("test local fault done");
        apb(1'b1, 32'h101c, 32'h0, 4'hf);
        seqs(2'h2, 4, 2);
        `CK("remoteFaultStatus", 1'b1, remoteFaultStatus)
        `CK("pcsTxData", ID, pcsTxData)
        `CK("pcsTxCtrl", 8'hff, pcsTxCtrl)
        `CK("irq", 1'b0, irq)
        apb(1'b1, 32'h101c, 32'h7, 4'hf);
        @(posedge core_clk);
        `CK("irq", 1'b1, irq)
        col(2'h0, CL + 3);
        `CK("remoteFaultStatus", 1'b0, remoteFaultStatus)
        $display("test remote fault done");
        apb(1'b1, 32'h1014, 32'h0, 4'hf);
        seqs(2'h1, 3, 2);
        seqs(2'h2, 1, 2);
        seqs(2'h1, 3, 2);
        `CK("localFaultStatus", 1'b0, localFaultStatus)
        col(2'h0, CL + 1);
        seqs(2'h1, 1, 2);
        `CK("localFaultStatus", 1'b0, localFaultStatus)
        seqs(2'h1, 3, 2);
        `CK("localFaultStatus", 1'b1, localFaultStatus)
        `CK("pcsTxData", MD, pcsTxData)
        clkEn <= 1'b0;
        col(2'h0, CL + 3);
        `CK("frozen localFaultStatus", 1'b1, localFaultStatus)
        `CK("pready", 1'b0, pready)
        clkEn <= 1'b1;
        apb(1'b1, 32'h1014, 32'h3, 4'hf);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CK("localFaultStatus", 1'b0, localFaultStatus)
        `CK("irq", 1'b0, irq)
        `CK("unidirectionalEn", 1'b0, unidirectionalEn)
        rst_b <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, 32'h1014, 32'h0, 4'hf);
        `CK("config", 32'h0, q)
        $display("test restart and reset done");
        summarize();
    end
endmodule
bind link_fault_reconciliation link_fault_reconciliation_checker #(.COL_LIMIT(COL_LIMIT)) chk_u (.core_clk,
    .rst_b, .clkEn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .rxData, .rxCtrl, .macTxData, .macTxCtrl,
    .pcsTxData, .pcsTxCtrl, .remoteFaultStatus, .localFaultStatus, .unidirectionalEn, .faultReportEn);
